//--- flash_host.sv
/*
 * host controller for a byte-wide parallel flash. software loads address,
 * data and an operation over classic wishbone; the controller issues the
 * coded write sequences and reads on the flash pins.
 * assumes the flash sits directly on the pins, sampled on ref_clk, and the
 * high-voltage select levels are produced by external switches.
 */
`default_nettype none

module flash_host
   import flash_host_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // flash pins
   output logic [18:0] addr_in,
   output logic [7:0] dataOut,
   output logic data_io_oe_n,
   input wire logic [7:0] data_io,
   output logic ceN,
   output logic oeN,
   output logic weN,
   output logic hv_select_addr_bit
);

   typedef enum logic [4:0] {
      S_IDLE = 5'b0_0001,
      S_ISSUE = 5'b0_0010,
      S_WAIT = 5'b0_0100,
      S_DELAY = 5'b0_1000,
      S_DONE = 5'b1_0000
   } seq_state_t;

   seq_state_t state_reg;
   logic [3:0] op_reg;
   logic [2:0] step_reg;
   logic [18:0] addr_reg;
   logic [7:0] data_reg;
   logic hv_reg;
   logic ceMode_reg;
   logic busy_reg;
   logic doneFlag_reg;
   logic errFlag_reg;
   logic eraseActive_reg;
   logic [7:0] rdataHold_reg;
   logic [15:0] delay_reg;
   logic ackReg;
   logic cycStart;
   logic cycDone;
   logic [7:0] cycRdata;
   logic [18:0] stepAddr;
   logic [7:0] stepData;
   logic stepWrite;
   logic lastStep;

   // ***********************************************************
   // sequence table
   // ***********************************************************
   function automatic logic [2:0] seq_len(input logic [3:0] op);
      case (op)
         OP_RESET3, OP_READ_ID: seq_len = 3'd3; // RULE_10 RULE_11
         OP_PROGRAM: seq_len = 3'd4; // RULE_13
         OP_BLOCK_ERASE, OP_CHIP_ERASE: seq_len = 3'd6; // RULE_14 RULE_16
         default: seq_len = 3'd1;
      endcase
   endfunction

   // unlock pair position in the sequence
   function automatic logic is_unlock(input logic [2:0] step, input logic [2:0] len);
      is_unlock = (step == 3'd0) || (step == 3'd1) ||
                  (len == 3'd6 && (step == 3'd3 || step == 3'd4));
   endfunction

   always_comb begin
      stepWrite = 1'b1;
      stepAddr = UNLOCK_ADDR1; // RULE_20
      stepData = CMD_UNLOCK1;
      if (is_unlock(step_reg, seq_len(op_reg)) && seq_len(op_reg) != 3'd1) begin
         if (step_reg == 3'd1 || step_reg == 3'd4) begin
            stepAddr = UNLOCK_ADDR2;
            stepData = CMD_UNLOCK2;
         end
      end else begin
         case (op_reg)
            OP_READ: begin
               stepWrite = 1'b0; // RULE_04 RULE_02 RULE_03 RULE_12 RULE_23
               stepAddr = addr_reg;
            end
            OP_RESET1: begin
               stepAddr = addr_reg;
               stepData = CMD_RESET; // RULE_09
            end
            OP_RESET3: stepData = CMD_RESET; // RULE_10
            OP_READ_ID: stepData = READ_ID_CMD; // RULE_11
            OP_PROGRAM: begin
               stepData = BYTE_WRITE_CMD; // RULE_13
               if (step_reg == 3'd3) begin
                  stepAddr = addr_reg; // RULE_01
                  stepData = data_reg;
               end
            end
            OP_BLOCK_ERASE: begin
               stepData = CMD_ERASE_SETUP; // RULE_14
               if (step_reg == 3'd5) begin
                  stepAddr = addr_reg;
                  stepData = SECTOR_WIPE_CMD;
               end
            end
            OP_CHIP_ERASE: begin
               stepData = CMD_ERASE_SETUP; // RULE_16
               if (step_reg == 3'd5) begin
                  stepData = CMD_CHIP_ERASE;
               end
            end
            OP_ADD_BLOCK: begin
               stepAddr = addr_reg;
               stepData = SECTOR_WIPE_CMD; // RULE_15
            end
            OP_SUSPEND: begin
               stepAddr = addr_reg;
               stepData = WIPE_PAUSE_CMD; // RULE_17
            end
            OP_RESUME: begin
               stepAddr = addr_reg;
               stepData = WIPE_CONTINUE_CMD; // RULE_17
            end
            OP_ABORT: begin
               stepAddr = addr_reg;
               stepData = CMD_ABORT; // RULE_19
            end
            default: begin
               // raw write lets software test fallback behaviour
               stepAddr = addr_reg; // RULE_18
               stepData = data_reg;
            end
         endcase
      end
   end

   assign lastStep = (step_reg + 3'd1 == seq_len(op_reg));
   assign cycStart = (state_reg == S_ISSUE);

   // ***********************************************************
   // bus cycle engine
   // ***********************************************************
   flash_bus_cycle u_cycle (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .start(cycStart),
      .isWrite(stepWrite),
      .ceMode(ceMode_reg),
      .addr(stepAddr),
      .wdata(stepData),
      .done(cycDone),
      .rdata_reg(cycRdata),
      .addrOut_reg(addr_in),
      .dataOut_reg(dataOut),
      .dataOe_n_reg(data_io_oe_n),
      .dataIn(data_io),
      .ceN_reg(ceN),
      .oeN_reg(oeN),
      .weN_reg(weN)
   );

   assign hv_select_addr_bit = hv_reg; // RULE_22

   // ***********************************************************
   // wishbone register access
   // ***********************************************************
   logic wbReq;
   logic goWrite;
   assign wbReq = wb_cyc_i && wb_stb_i && !ackReg;
   assign goWrite = wbReq && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[3] &&
                    wb_dat_i[CTRL_GO_BIT] && state_reg == S_IDLE;
   assign wb_ack_o = ackReg;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ackReg <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ackReg <= wbReq;
         wb_dat_o <= 32'h0000_0000;
         if (wbReq && !wb_we_i) begin
            case (wb_adr_i)
               REG_CTRL: wb_dat_o <= {22'h0, ceMode_reg, hv_reg, 4'h0, op_reg};
               REG_ADDR: wb_dat_o <= {13'h0, addr_reg};
               REG_DATA: wb_dat_o <= {24'h0, rdataHold_reg};
               REG_STATUS: wb_dat_o <= {28'h0, eraseActive_reg, errFlag_reg,
                                        doneFlag_reg, busy_reg};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         op_reg <= OP_READ;
         addr_reg <= 19'h0_0000;
         data_reg <= 8'h00;
         hv_reg <= 1'b0;
         ceMode_reg <= 1'b0;
      end else if (wbReq && wb_we_i && state_reg == S_IDLE) begin
         case (wb_adr_i)
            REG_CTRL: begin
               if (wb_sel_i[0]) op_reg <= wb_dat_i[CTRL_OP_LSB +: CTRL_OP_W];
               if (wb_sel_i[1]) begin
                  hv_reg <= wb_dat_i[CTRL_HV_BIT];
                  ceMode_reg <= wb_dat_i[CTRL_CEMODE_BIT];
               end
            end
            REG_ADDR: begin
               if (wb_sel_i[0]) addr_reg[7:0] <= wb_dat_i[7:0];
               if (wb_sel_i[1]) addr_reg[15:8] <= wb_dat_i[15:8];
               if (wb_sel_i[2]) addr_reg[18:16] <= wb_dat_i[18:16];
            end
            REG_DATA: if (wb_sel_i[0]) data_reg <= wb_dat_i[7:0];
            default: ;
         endcase
      end
   end

   // ***********************************************************
   // sequencer
   // ***********************************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= S_IDLE;
         step_reg <= 3'd0;
         busy_reg <= 1'b0;
         delay_reg <= 16'h0000;
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (goWrite) begin
                  busy_reg <= 1'b1;
                  step_reg <= 3'd0;
                  state_reg <= S_ISSUE;
               end
            end
            S_ISSUE: state_reg <= S_WAIT;
            S_WAIT: begin
               if (cycDone) begin
                  if (lastStep) begin
                     delay_reg <= 16'h0000;
                     state_reg <= S_DELAY;
                  end else begin
                     step_reg <= step_reg + 3'd1;
                     state_reg <= S_ISSUE;
                  end
               end
            end
            S_DELAY: begin
               // settle after reset while an erase runs
               delay_reg <= delay_reg + 16'h0001;
               if (!eraseActive_reg || (op_reg != OP_RESET1 && op_reg != OP_RESET3) ||
                   int'(delay_reg) + 1 >= RESET_WAIT_CYC) begin // RULE_21
                  state_reg <= S_DONE;
               end
            end
            S_DONE: begin
               busy_reg <= 1'b0;
               state_reg <= S_IDLE;
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // ***********************************************************
   // status tracking
   // ***********************************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         doneFlag_reg <= 1'b0;
         errFlag_reg <= 1'b0;
         eraseActive_reg <= 1'b0;
         rdataHold_reg <= 8'h00;
      end else begin
         if (goWrite) begin
            doneFlag_reg <= 1'b0;
            errFlag_reg <= 1'b0;
         end
         if (state_reg == S_WAIT && cycDone && !stepWrite) begin
            rdataHold_reg <= cycRdata;
            errFlag_reg <= cycRdata[ERROR_BIT] &&
                           cycRdata[TOGGLE_BIT] != rdataHold_reg[TOGGLE_BIT];
         end
         if (state_reg == S_DONE) begin
            doneFlag_reg <= 1'b1;
            if (op_reg == OP_BLOCK_ERASE || op_reg == OP_CHIP_ERASE) begin
               eraseActive_reg <= 1'b1;
            end
            if (op_reg == OP_RESET1 || op_reg == OP_RESET3 || op_reg == OP_ABORT) begin
               eraseActive_reg <= 1'b0; // RULE_24
            end
         end
         // a finished poll with bit seven high, bit three low and bit six unchanged since the last read ends the erase
         if (state_reg == S_WAIT && cycDone && !stepWrite && cycRdata[POLL_BIT] &&
             cycRdata[ERASE_WINDOW_BIT] == 1'b0 && op_reg == OP_READ) begin
            eraseActive_reg <= eraseActive_reg &&
                               cycRdata[TOGGLE_BIT] != rdataHold_reg[TOGGLE_BIT];
         end
      end
   end

   a_unlock_first: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE_10
      (cycStart && step_reg == 3'd0 && seq_len(op_reg) > 3'd1) |->
      (stepAddr == UNLOCK_ADDR1 && stepData == CMD_UNLOCK1))
      else $error("sequence did not open with first unlock");

   a_program_data: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE_13
      (cycStart && op_reg == OP_PROGRAM && step_reg == 3'd3) |->
      (stepAddr == addr_reg && stepData == data_reg))
      else $error("program cycle lost address or data");

   a_erase_confirm: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE_16
      (cycStart && op_reg == OP_CHIP_ERASE && step_reg == 3'd5) |->
      (stepData == CMD_CHIP_ERASE && stepAddr == UNLOCK_ADDR1))
      else $error("chip erase confirm wrong");

   a_ack_one: assert property (@(posedge ref_clk) disable iff (!rstn)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

endmodule

`default_nettype wire

//--- flash_host_pkg.sv
/*
 * constants for the parallel flash host controller: register map, command
 * codes, unlock addresses, pin field positions and timing counts.
 * assumes a 10 MHz clock and a byte-wide flash on a 19-bit address bus.
 */
// Functional notes
// (RULE_01) device latches full address each write
// (RULE_02) high-voltage bit nine selects signature codes
// (RULE_03) high-voltage bit one reads block protection
// (RULE_04) reads give array, signature or status bits
// (RULE_05) outputs valid only with both enables low
// (RULE_06) chip-enable write: address falls, data rises
// (RULE_07) write-enable write: address falls, data rises
// (RULE_08) chip enable high deselects the device
// (RULE_09) single F0h write returns array read
// (RULE_10) three-cycle reset: AAh, 55h, F0h
// (RULE_11) unlock then 90h gives signature reads
// (RULE_12) 90h then bit one reads protection
// (RULE_13) program: unlock, A0h, then address and data
// (RULE_14) block erase: unlock, 80h, unlock, 30h
// (RULE_15) extra blocks within window, bit three shows
// (RULE_16) chip erase: unlock, 80h, unlock, 10h
// (RULE_17) B0h suspends erase, 30h resumes
// (RULE_18) unmatched sequence falls back to array read
// (RULE_19) 00h resets controller during entry or id
// (RULE_20) upper address bits ignored in unlock match
// (RULE_21) host waits after reset during block erase
// (RULE_22) host holds select voltage during protect
// (RULE_23) protection read gives 01h or 00h
// (RULE_24) power-up returns decoder to array read
// (RULE_25) host releases data bus before output enable
`default_nettype none

package flash_host_pkg;

   // ***********************************************************
   // register map (word offsets as byte addresses)
   // ***********************************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h4;
   localparam logic [3:0] REG_DATA = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hC;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;

   // ctrl register fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_OP_W = 4;
   localparam int CTRL_HV_BIT = 8;
   localparam int CTRL_CEMODE_BIT = 9;
   localparam int CTRL_GO_BIT = 31;

   // status register fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_ERR_BIT = 2;

   // ***********************************************************
   // operation codes written by software
   // ***********************************************************
   localparam logic [3:0] OP_READ = 4'h0;
   localparam logic [3:0] OP_RESET1 = 4'h1;
   localparam logic [3:0] OP_RESET3 = 4'h2;
   localparam logic [3:0] OP_READ_ID = 4'h3;
   localparam logic [3:0] OP_PROGRAM = 4'h4;
   localparam logic [3:0] OP_BLOCK_ERASE = 4'h5;
   localparam logic [3:0] OP_ADD_BLOCK = 4'h6;
   localparam logic [3:0] OP_CHIP_ERASE = 4'h7;
   localparam logic [3:0] OP_SUSPEND = 4'h8;
   localparam logic [3:0] OP_RESUME = 4'h9;
   localparam logic [3:0] OP_ABORT = 4'hA;
   localparam logic [3:0] OP_WRITE_RAW = 4'hB;

   // ***********************************************************
   // flash command bytes and unlock addresses
   // ***********************************************************
   localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
   localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
   localparam logic [7:0] CMD_RESET = 8'hF0;
   localparam logic [7:0] READ_ID_CMD = 8'h90;
   localparam logic [7:0] BYTE_WRITE_CMD = 8'hA0;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] SECTOR_WIPE_CMD = 8'h30;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
   localparam logic [7:0] WIPE_PAUSE_CMD = 8'hB0;
   localparam logic [7:0] WIPE_CONTINUE_CMD = 8'h30;
   localparam logic [7:0] CMD_ABORT = 8'h00;
   localparam logic [18:0] UNLOCK_ADDR1 = 19'h0_5555;
   localparam logic [18:0] UNLOCK_ADDR2 = 19'h0_2AAA;

   // status bit positions in read data, and the high-voltage select address bit
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int ERROR_BIT = 5;
   localparam int ERASE_WINDOW_BIT = 3;
   localparam int HV_SELECT_ADDR_BIT = 9;

   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int CLK_HZ = 10_000_000;
   localparam int ACCESS_NS = 70;
   localparam int ACCESS_CYC = (ACCESS_NS * (CLK_HZ / 1_000_000) + 999) / 1000 + 1;
   localparam int PULSE_CYC = 2;
   localparam int RESET_WAIT_US = 5;
   localparam int RESET_WAIT_CYC = RESET_WAIT_US * (CLK_HZ / 1_000_000);

endpackage

`default_nettype wire

//--- flash_bus_cycle.sv
/*
 * one flash bus cycle: a write (address on the falling enable edge, data on
 * the rising edge) or a read gated by chip and output enable.
 * assumes the flash pins are sampled synchronously to ref_clk.
 */
`default_nettype none

module flash_bus_cycle
   import flash_host_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // request
   input wire logic start,
   input wire logic isWrite,
   input wire logic ceMode,
   input wire logic [18:0] addr,
   input wire logic [7:0] wdata,
   output logic done,
   output logic [7:0] rdata_reg,
   // flash pins
   output logic [18:0] addrOut_reg,
   output logic [7:0] dataOut_reg,
   output logic dataOe_n_reg,
   input wire logic [7:0] dataIn,
   output logic ceN_reg,
   output logic oeN_reg,
   output logic weN_reg
);

   typedef enum logic [4:0] {
      C_IDLE = 5'b0_0001,
      C_SETUP = 5'b0_0010,
      C_STROBE = 5'b0_0100,
      C_HOLD = 5'b0_1000,
      C_REL = 5'b1_0000
   } cyc_state_t;

   cyc_state_t state_reg;
   logic [3:0] cnt_reg;
   logic opWrite_reg;

   assign done = (state_reg == C_REL);

   // ***********************************************************
   // cycle sequencer
   // ***********************************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= C_IDLE;
         cnt_reg <= 4'h0;
         opWrite_reg <= 1'b0;
         addrOut_reg <= 19'h0_0000;
         dataOut_reg <= 8'h00;
         dataOe_n_reg <= 1'b1;
         ceN_reg <= 1'b1;
         oeN_reg <= 1'b1;
         weN_reg <= 1'b1;
         rdata_reg <= 8'h00;
      end else begin
         case (state_reg)
            C_IDLE: begin
               if (start) begin
                  addrOut_reg <= addr;
                  opWrite_reg <= isWrite;
                  dataOut_reg <= wdata;
                  // bus released before a read enables outputs
                  dataOe_n_reg <= !isWrite; // RULE_25
                  state_reg <= C_SETUP;
               end
            end
            C_SETUP: begin
               if (opWrite_reg) begin
                  // first enable falls here; the strobe falling next cycle latches the address
                  if (ceMode) begin
                     weN_reg <= 1'b0; // RULE_06
                  end else begin
                     ceN_reg <= 1'b0; // RULE_07
                  end
               end else begin
                  ceN_reg <= 1'b0; // RULE_05
               end
               state_reg <= C_STROBE;
               cnt_reg <= 4'h0;
            end
            C_STROBE: begin
               if (opWrite_reg) begin
                  if (ceMode) begin
                     ceN_reg <= 1'b0; // RULE_06
                  end else begin
                     weN_reg <= 1'b0; // RULE_07
                  end
               end else begin
                  oeN_reg <= 1'b0; // RULE_05
               end
               state_reg <= C_HOLD;
            end
            C_HOLD: begin
               cnt_reg <= cnt_reg + 4'h1;
               if (int'(cnt_reg) + 1 >= (opWrite_reg ? PULSE_CYC : ACCESS_CYC)) begin
                  if (!opWrite_reg) begin
                     rdata_reg <= dataIn; // RULE_04
                  end
                  // rising enable latches data; deselect in the same cycle
                  ceN_reg <= 1'b1; // RULE_08
                  weN_reg <= 1'b1;
                  oeN_reg <= 1'b1;
                  state_reg <= C_REL;
               end
            end
            C_REL: begin
               dataOe_n_reg <= 1'b1;
               state_reg <= C_IDLE;
            end
            default: state_reg <= C_IDLE;
         endcase
      end
   end

   a_read_gated: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE_25
      (!oeN_reg) |-> (dataOe_n_reg && !ceN_reg))
      else $error("read enabled while host drives data");

   // write strobe only with outputs off and host data on the bus
   a_write_oe_high: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE_07
      (!weN_reg) |-> (oeN_reg && !dataOe_n_reg))
      else $error("write strobe with outputs enabled or bus released");

endmodule

`default_nettype wire

//--- flash_model.sv
/*
 * behavioural model of the byte-wide flash on the host pins.
 * assumes strobes, address and data change together on the host clock.
 */
`default_nettype none

module flash_model #(
   parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
   parameter logic [7:0] PART_CODE = 8'hC3, // arbitrary value
   parameter logic [7:0] PROT_BLK = 8'h24
) (
   // flash pins
   input wire logic [18:0] addrIn,
   input wire logic [7:0] busIn,
   input wire logic ceN,
   input wire logic oeN,
   input wire logic weN,
   input wire logic hvSel,
   // read side
   output logic [7:0] rdOut,
   output logic rdDrive
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [int];
   logic [18:0] la;
   logic act = 0;
   logic idMode = 0;
   logic er = 0;
   logic win = 0;
   int step = 0;

   task automatic wipe(input logic [2:0] b);
      foreach (mem[k])
         if (k[18:16] == b && !PROT_BLK[b]) mem[k] = 8'hFF;
   endtask

   // ***********************************************************
   // command decoder
   // ***********************************************************
   task automatic cmd(input logic [18:0] a, input logic [7:0] d);
      logic u1;
      logic u2;
      u1 = a[14:0] == 15'h5555;
      u2 = a[14:0] == 15'h2AAA;
      idMode = 0;
      case (step)
         1: step = (u2 && d == 8'h55) ? 2 : 0;
         2: begin
            if (er && u1 && d == 8'h10) mem.delete();
            if (er && d == 8'h30) wipe(a[18:16]);
            win = er && d == 8'h30;
            idMode = u1 && d == 8'h90;
            step = (u1 && d == 8'hA0) ? 3 : 0;
            er = !er && u1 && d == 8'h80;
         end
         3: begin
            if (!PROT_BLK[a[18:16]]) mem[a] = (mem.exists(a) ? mem[a] : 8'hFF) & d;
            step = 0;
         end
         default: begin
            if (win && d == 8'h30) wipe(a[18:16]);
            win = win && d inside {8'h30, 8'hB0};
            step = (u1 && d == 8'hAA) ? 1 : 0;
         end
      endcase
   endtask

   always @(negedge weN or negedge ceN)
      if (!weN && !ceN && oeN) begin
         la = addrIn;
         act = 1;
      end
   always @(posedge weN or posedge ceN)
      if (act) begin
         act = 0;
         cmd(la, busIn);
      end
   // reevaluated as outputs open, so array updates at the same address show
   always @(addrIn, idMode, hvSel, ceN, oeN) begin
      rdDrive = !ceN && !oeN;
      if (hvSel || idMode)
         rdOut = addrIn[1] ? {7'h00, PROT_BLK[addrIn[18:16]]} :
            (addrIn[0] ? PART_CODE : MAKER_CODE);
      else
         rdOut = mem.exists(addrIn) ? mem[addrIn] : 8'hFF;
   end
endmodule

`default_nettype wire

//--- tb_flash_host.sv
/*
 * self-checking bench for the flash host controller.
 * assumes the flash model answers on the pins with no delay.
 */
`default_nettype none

module tb_flash_host;
   import flash_host_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
   localparam logic [7:0] PART = 8'hC3; // arbitrary value
   localparam logic [2:0] BLK [6] = '{3'd0, 3'd1, 3'd3, 3'd4, 3'd6, 3'd7};
   localparam logic [3:0] EXITS [4] = '{OP_RESET1, OP_RESET3, OP_ABORT, OP_WRITE_RAW};
   logic ref_clk = 0;
   logic rstn = 0;
   logic wbCyc = 0;
   logic wbStb = 0;
   logic wbWe = 0;
   logic [3:0] wbAdr = 0;
   logic [3:0] wbSel = 0;
   logic [31:0] wbDat = 0;
   logic [31:0] wbQ;
   logic [31:0] q;
   logic wbAck;
   logic [18:0] fAddr;
   logic [7:0] hOut;
   logic [7:0] mOut;
   logic [7:0] lastBus = 0;
   logic hOeN, ceN, oeN, weN, hv, mDrv;
   logic [18:0] pa [6];
   logic [7:0] pd [6];
   logic [7:0] erased = 0;
   int error_cnt = 0;
   int n_compared = 0;
   int seed = 32'h23cd_68ce;
   int r;
   time t0;
   // released bus shows the inverse of its last level
   wire logic [7:0] bus = !hOeN ? hOut : (mDrv ? mOut : ~lastBus);

   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      if (!hOeN || mDrv) lastBus <= bus;

   flash_host DUT (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbQ),
      .wb_ack_o(wbAck), .addr_in(fAddr), .dataOut(hOut), .data_io_oe_n(hOeN), .data_io(bus),
      .ceN(ceN), .oeN(oeN), .weN(weN), .hv_select_addr_bit(hv));
   flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash (.addrIn(fAddr), .busIn(bus),
      .ceN(ceN), .oeN(oeN), .weN(weN), .hvSel(hv), .rdOut(mOut), .rdDrive(mDrv));

   // ***********************************************************
   // tasks
   // ***********************************************************
   task automatic complete_run;
      if (error_cnt == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic fail(input string m);
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, m);
      complete_run();
   endtask
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int n;
      wbCyc <= 1;
      wbStb <= 1;
      wbWe <= we;
      wbAdr <= a;
      wbDat <= d;
      wbSel <= 4'hF;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      q = wbQ;
      wbCyc <= 0;
      wbStb <= 0;
      if (n >= 20) fail("no bus answer");
      @(posedge ref_clk);
   endtask
   task automatic op(input logic [3:0] c, input logic [18:0] a, input logic [7:0] d,
         input logic ce, input logic hvOn);
      int n;
      wb(1, REG_ADDR, {13'h0, a});
      wb(1, REG_DATA, {24'h0, d});
      wb(1, REG_CTRL, {1'b1, 21'h0, ce, hvOn, 4'h0, c});
      n = 0;
      do begin
         wb(0, REG_STATUS, 0);
         n++;
      end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 400);
      if (n >= 400) fail("stuck busy");
      chk(1, q[STAT_DONE_BIT]);
   endtask
   task automatic rdChk(input logic [18:0] a, input logic hvOn, input logic [7:0] exp);
      op(OP_READ, a, 0, 0, hvOn);
      wb(0, REG_DATA, 0);
      chk({24'h0, exp}, {24'h0, q[7:0]});
   endtask
   function automatic logic [7:0] expd(input int i);
      return erased[BLK[i]] ? 8'hFF : pd[i];
   endfunction
   task automatic checkAll;
      for (int i = 0; i < 6; i++)
         rdChk(pa[i], 0, expd(i));
   endtask

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      repeat (2) @(posedge ref_clk);
      rstn <= 1;
      @(posedge ref_clk);
      wb(0, 4'h2, 0);
      chk(0, q);
      rdChk(19'h0_1234, 0, 8'hFF);
      for (int i = 0; i < 6; i++) begin
         r = $random(seed);
         pa[i] = {BLK[i], r[15:0]};
         pd[i] = r[23:16];
         op(OP_PROGRAM, pa[i], pd[i], i[0], 0);
      end
      op(OP_PROGRAM, pa[0], 8'h0F, 1, 0);
      pd[0] = pd[0] & 8'h0F;
      checkAll();
      for (int k = 0; k < 4; k++) begin
         op(OP_READ_ID, 0, 0, 0, 0);
         rdChk(19'h0_0000, 0, MAKER);
         rdChk(19'h0_0001, 0, PART);
         rdChk({3'd5, 16'h0002}, 0, 8'h01);
         op(EXITS[k], 0, 8'h77, 0, 0);
         rdChk(pa[k], 0, expd(k));
      end
      rdChk({3'd2, 16'h0002}, 1, 8'h01);
      rdChk({3'd3, 16'h0002}, 1, 8'h00);
      rdChk({3'd0, 16'h0001}, 1, PART);
      rdChk({3'd0, 16'h0000}, 1, MAKER);
      op(OP_BLOCK_ERASE, pa[0], 0, 0, 0);
      op(OP_ADD_BLOCK, pa[1], 0, 0, 0);
      op(OP_SUSPEND, 0, 0, 0, 0);
      op(OP_RESUME, 0, 0, 0, 0);
      t0 = $time;
      op(OP_RESET1, 0, 0, 0, 0);
      chk(1, ($time - t0) >= RESET_WAIT_CYC * 100);
      erased = 8'h03;
      checkAll();
      op(OP_CHIP_ERASE, 0, 0, 1, 0);
      erased = 8'hFF;
      checkAll();
      complete_run();
   end
endmodule

`default_nettype wire
